// File: rtl/tios_defs.svh
`ifndef TIOS_DEFS_SVH
`define TIOS_DEFS_SVH
// register byte offsets on the bus
`define TIOS_OFF_SEL1 12'h000
`define TIOS_OFF_SEL2 12'h004
`define TIOS_OFF_GRA1 12'h008
`define TIOS_OFF_GRA2 12'h00c
`define TIOS_OFF_STAT 12'h010
// select field positions
`define TIOS_SEL_TOP  3
`define TIOS_SEL_LVL  2
// reset values
`define TIOS_SEL_RST  8'h00
`define TIOS_GRA_RST  16'hffff
`define TIOS_RD_RST   32'h0000_0000
`endif

// File: rtl/tios_pkg.sv
`default_nettype none
package tios_pkg;
	// action of the pin at compare match, the two low select bits
	typedef enum logic [1:0] {
		TIOS_ACT_OFF  = 2'b00,
		TIOS_ACT_LOW  = 2'b01,
		TIOS_ACT_HIGH = 2'b10,
		TIOS_ACT_TOG  = 2'b11
	} tios_act_t;
	typedef struct packed {
		logic [7:0]  sel1;
		logic [7:0]  sel2;
		logic [15:0] gra1;
		logic [15:0] gra2;
		logic        selwr1;
		logic        selwr2;
		logic [31:0] prdata;
	} tios_top_st_t;
	typedef struct packed {
		logic pin;
		logic prev;
		logic primed;
	} tios_chan_st_t;
	typedef struct packed {
		logic eq_prev;
	} tios_cmp_st_t;
endpackage
`default_nettype wire

// File: rtl/tios_chan_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tios_chan_if;
	logic [3:0]  sel;
	logic        sel_wr;
	logic [15:0] cnt;
	logic [15:0] gra;
	logic        match;
	logic        pin_i;
	logic        ch0_evt;
	logic        capture;
	logic        pin_o;
	logic        pin_oe_n;
	modport core (output sel, sel_wr, cnt, gra, pin_i, ch0_evt, input match, capture, pin_o, pin_oe_n);
	modport unit (input sel, sel_wr, match, pin_i, ch0_evt, output capture, pin_o, pin_oe_n);
	modport cmpr (input cnt, gra, output match);
endinterface
`default_nettype wire

// File: rtl/tios_cmp.sv
`timescale 1ns/1ps
`default_nettype none
module tios_cmp
	import tios_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	tios_chan_if.cmpr bus
);
	tios_cmp_st_t st;
	tios_cmp_st_t next_st;
	logic         eq;

	// one pulse per match: a prescaled counter may sit on the value for many cycles
	assign eq        = (bus.cnt == bus.gra);
	assign bus.match = eq & ~st.eq_prev;

	always_comb begin
		next_st         = st;
		next_st.eq_prev = eq;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end
endmodule
`default_nettype wire

// File: rtl/tios_chan.sv
`timescale 1ns/1ps
`default_nettype none
`include "tios_defs.svh"
module tios_chan
	import tios_pkg::*;
#(
	parameter bit IS_CHAN1 = 1'b0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	tios_chan_if.unit bus
);
	tios_chan_st_t st;
	tios_chan_st_t next_st;
	tios_act_t     act;
	logic          out_mode;
	logic          rise;
	logic          fall;

	assign act      = tios_act_t'(bus.sel[1:0]);
	assign out_mode = ~bus.sel[`TIOS_SEL_TOP];
	// output buffer on only in compare mode with an action selected
	assign bus.pin_oe_n = ~(out_mode && act != TIOS_ACT_OFF);
	assign bus.pin_o    = st.pin;

	// edges are only trusted once a previous sample exists
	assign rise = st.primed & bus.pin_i & ~st.prev;
	assign fall = st.primed & ~bus.pin_i & st.prev;

	always_comb begin
		bus.capture = 1'b0;
		if (bus.sel[`TIOS_SEL_TOP]) begin
			if (IS_CHAN1 && bus.sel[`TIOS_SEL_LVL]) begin
				bus.capture = bus.ch0_evt;
			end else if (bus.sel[1]) begin
				bus.capture = rise | fall;
			end else if (bus.sel[0]) begin
				bus.capture = fall;
			end else begin
				bus.capture = rise;
			end
		end
	end

	// pin level: a new select value loads the initial level, matches then act on it
	always_comb begin
		next_st        = st;
		next_st.prev   = bus.pin_i;
		next_st.primed = 1'b1;
		if (bus.sel_wr && out_mode) begin
			next_st.pin = bus.sel[`TIOS_SEL_LVL];
		end else if (bus.match && out_mode) begin
			unique case (act)
				TIOS_ACT_OFF:  next_st.pin = st.pin;
				TIOS_ACT_LOW:  next_st.pin = 1'b0;
				TIOS_ACT_HIGH: next_st.pin = 1'b1;
				TIOS_ACT_TOG:  next_st.pin = ~st.pin;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end
endmodule
`default_nettype wire

// File: rtl/tios_top.sv
// Summary of operation
// - code 0x01 starts at bit2, match drives low
// - code 0x10 starts at bit2, match drives high
// - code 0x11 starts at bit2, match toggles pin
// - capture 1x00 captures on pin rising edge
// - capture 1x01 captures on pin falling edge
// - capture 1x1x captures on both pin edges
// - channel 1 codes 10xx use its pin
// - channel 1 codes 11xx use channel 0 event
// - channel 2 capture always uses its pin
//
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "tios_defs.svh"
module tios_top
	import tios_pkg::*;
(
	input  wire logic        CLK,
	input  wire logic        RST,
	input  wire logic        CE,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	input  wire logic [3:0]  PSTRB,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic [15:0] CNT1,
	input  wire logic [15:0] CNT2,
	input  wire logic        CH0_EVENT,
	input  wire logic        CH1_PIN_I,
	output logic             CH1_PIN_O,
	output logic             CH1_PIN_OE_N,
	input  wire logic        CH2_PIN_I,
	output logic             CH2_PIN_O,
	output logic             CH2_PIN_OE_N
);
	tios_top_st_t st;
	tios_top_st_t next_st;
	logic         wr;
	logic         hit;
	tios_chan_if  c1 ();
	tios_chan_if  c2 ();

	// channel 1 carries the cascade input, channel 2 has none
	assign c1.sel     = st.sel1[3:0];
	assign c1.sel_wr  = st.selwr1;
	assign c1.cnt     = CNT1;
	assign c1.gra     = st.gra1;
	assign c1.pin_i   = CH1_PIN_I;
	assign c1.ch0_evt = CH0_EVENT;
	assign c2.sel     = st.sel2[3:0];
	assign c2.sel_wr  = st.selwr2;
	assign c2.cnt     = CNT2;
	assign c2.gra     = st.gra2;
	assign c2.pin_i   = CH2_PIN_I;
	assign c2.ch0_evt = 1'b0;

	tios_cmp u_cmp1 (
		.clk (CLK),
		.rst (RST),
		.ce  (CE),
		.bus (c1.cmpr)
	);
	tios_cmp u_cmp2 (
		.clk (CLK),
		.rst (RST),
		.ce  (CE),
		.bus (c2.cmpr)
	);
	tios_chan #(.IS_CHAN1(1'b1)) u_ch1 (
		.clk (CLK),
		.rst (RST),
		.ce  (CE),
		.bus (c1.unit)
	);
	tios_chan #(.IS_CHAN1(1'b0)) u_ch2 (
		.clk (CLK),
		.rst (RST),
		.ce  (CE),
		.bus (c2.unit)
	);

	assign CH1_PIN_O    = c1.pin_o;
	assign CH1_PIN_OE_N = c1.pin_oe_n;
	assign CH2_PIN_O    = c2.pin_o;
	assign CH2_PIN_OE_N = c2.pin_oe_n;

	// bus answers: no wait states, but a frozen block holds the transfer
	assign hit = (PADDR == `TIOS_OFF_SEL1) || (PADDR == `TIOS_OFF_SEL2) || (PADDR == `TIOS_OFF_GRA1)
		|| (PADDR == `TIOS_OFF_GRA2) || (PADDR == `TIOS_OFF_STAT);
	assign wr      = PSEL & PENABLE & PWRITE & CE;
	assign PREADY  = CE;
	assign PSLVERR = PSEL & PENABLE & ~hit;
	assign PRDATA  = st.prdata;

	// registers, write effects, captures and read data staging
	always_comb begin
		logic [31:0] rd;
		rd             = `TIOS_RD_RST;
		next_st        = st;
		next_st.selwr1 = 1'b0;
		next_st.selwr2 = 1'b0;
		unique case (PADDR)
			`TIOS_OFF_SEL1: rd = {24'h00_0000, st.sel1};
			`TIOS_OFF_SEL2: rd = {24'h00_0000, st.sel2};
			`TIOS_OFF_GRA1: rd = {16'h0000, st.gra1};
			`TIOS_OFF_GRA2: rd = {16'h0000, st.gra2};
			`TIOS_OFF_STAT: rd = {28'h000_0000, ~CH2_PIN_OE_N, CH2_PIN_O, ~CH1_PIN_OE_N, CH1_PIN_O};
			default:        rd = `TIOS_RD_RST;
		endcase
		// read data is staged in the setup cycle so it leaves a flop
		if (PSEL && !PENABLE) begin
			next_st.prdata = rd;
		end
		if (wr && PSTRB[0] && PADDR == `TIOS_OFF_SEL1) begin
			next_st.sel1   = PWDATA[7:0];
			next_st.selwr1 = 1'b1;
		end
		if (wr && PSTRB[0] && PADDR == `TIOS_OFF_SEL2) begin
			next_st.sel2   = PWDATA[7:0];
			next_st.selwr2 = 1'b1;
		end
		if (wr && PADDR == `TIOS_OFF_GRA1) begin
			if (PSTRB[0]) next_st.gra1[7:0] = PWDATA[7:0];
			if (PSTRB[1]) next_st.gra1[15:8] = PWDATA[15:8];
		end
		if (wr && PADDR == `TIOS_OFF_GRA2) begin
			if (PSTRB[0]) next_st.gra2[7:0] = PWDATA[7:0];
			if (PSTRB[1]) next_st.gra2[15:8] = PWDATA[15:8];
		end
		// a capture beats a software write in the same cycle
		if (c1.capture) begin
			next_st.gra1 = CNT1;
		end
		if (c2.capture) begin
			next_st.gra2 = CNT2;
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			st.sel1   <= `TIOS_SEL_RST;
			st.sel2   <= `TIOS_SEL_RST;
			st.gra1   <= `TIOS_GRA_RST;
			st.gra2   <= `TIOS_GRA_RST;
			st.selwr1 <= 1'b0;
			st.selwr2 <= 1'b0;
			st.prdata <= `TIOS_RD_RST;
		end else if (CE) begin
			st <= next_st;
		end
	end

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);

	// edges as the capture logic sees them: none in the first cycle after reset,
	// and only when the cycle before was enabled, so the held sample is one cycle old
	sequence s_pin1_rise;
		!$past(RST) && $past(CE) && CH1_PIN_I && !$past(CH1_PIN_I);
	endsequence
	sequence s_pin1_fall;
		!$past(RST) && $past(CE) && !CH1_PIN_I && $past(CH1_PIN_I);
	endsequence
	sequence s_pin1_edge;
		!$past(RST) && $past(CE) && CH1_PIN_I != $past(CH1_PIN_I);
	endsequence
	sequence s_pin2_rise;
		!$past(RST) && $past(CE) && CH2_PIN_I && !$past(CH2_PIN_I);
	endsequence
	sequence s_pin2_fall;
		!$past(RST) && $past(CE) && !CH2_PIN_I && $past(CH2_PIN_I);
	endsequence
	sequence s_pin2_edge;
		!$past(RST) && $past(CE) && CH2_PIN_I != $past(CH2_PIN_I);
	endsequence
	sequence s_match1;
		CE && c1.match && !st.selwr1;
	endsequence
	sequence s_match2;
		CE && c2.match && !st.selwr2;
	endsequence

	a_match_low: assert property (
		s_match1 and (st.sel1[3:0] ==? 4'b0?01) |=> !CH1_PIN_O)
		else $error("pin not low after match");
	a_match_high: assert property (
		s_match1 and (st.sel1[3:0] ==? 4'b0?10) |=> CH1_PIN_O)
		else $error("pin not high after match");
	a_match_toggle: assert property (
		s_match1 and (st.sel1[3:0] ==? 4'b0?11) |=> CH1_PIN_O != $past(CH1_PIN_O))
		else $error("pin did not toggle");
	a_init_level: assert property (
		CE && st.selwr1 && !st.sel1[3] |=> CH1_PIN_O == $past(st.sel1[2]))
		else $error("initial level not loaded");
	a_cap_rise: assert property (
		CE && c2.capture && (st.sel2[3:0] ==? 4'b1?00) |-> s_pin2_rise)
		else $error("rise capture without rising edge");
	a_cap_fall: assert property (
		CE && c2.capture && (st.sel2[3:0] ==? 4'b1?01) |-> s_pin2_fall)
		else $error("fall capture without falling edge");
	a_cap_both: assert property (
		CE && c2.capture && (st.sel2[3:0] ==? 4'b1?1?) |-> s_pin2_edge)
		else $error("both-edge capture without edge");
	a_ch1_pin_src: assert property (
		(CE && st.sel1[3:0] == 4'b1000) and s_pin1_rise |-> c1.capture)
		else $error("channel 1 pin rise missed");
	a_ch1_cascade: assert property (
		st.sel1[3:2] == 2'b11 |-> c1.capture == CH0_EVENT)
		else $error("cascade capture wrong");
	a_ch2_no_casc: assert property (
		CE && st.sel2[3:2] == 2'b11 && c2.capture |-> s_pin2_edge)
		else $error("channel 2 captured without pin edge");
	a_out_off: assert property (
		!st.sel1[3] && st.sel1[1:0] == 2'b00 |-> CH1_PIN_OE_N)
		else $error("pin driven while disabled");
	a_cap_load: assert property (
		CE && c1.capture |=> st.gra1 == $past(CNT1))
		else $error("captured value not the counter");
	a_cap2_load: assert property (
		CE && c2.capture |=> st.gra2 == $past(CNT2))
		else $error("channel 2 captured value not the counter");

	// channel 2 compare side mirrors channel 1
	a_match2_low: assert property (
		s_match2 and (st.sel2[3:0] ==? 4'b0?01) |=> !CH2_PIN_O)
		else $error("channel 2 pin not low after match");
	a_match2_high: assert property (
		s_match2 and (st.sel2[3:0] ==? 4'b0?10) |=> CH2_PIN_O)
		else $error("channel 2 pin not high after match");
	a_match2_toggle: assert property (
		s_match2 and (st.sel2[3:0] ==? 4'b0?11) |=> CH2_PIN_O != $past(CH2_PIN_O))
		else $error("channel 2 pin did not toggle");
	a_init_level2: assert property (
		CE && st.selwr2 && !st.sel2[3] |=> CH2_PIN_O == $past(st.sel2[2]))
		else $error("channel 2 initial level not loaded");
	a_out2_off: assert property (
		!st.sel2[3] && st.sel2[1:0] == 2'b00 |-> CH2_PIN_OE_N)
		else $error("channel 2 pin driven while disabled");

	// a pin level only moves on a select write or a match, never on its own
	a_pin1_hold: assert property (
		CE && !st.selwr1 && !c1.match |=> CH1_PIN_O == $past(CH1_PIN_O))
		else $error("channel 1 pin moved without cause");
	a_pin2_hold: assert property (
		CE && !st.selwr2 && !c2.match |=> CH2_PIN_O == $past(CH2_PIN_O))
		else $error("channel 2 pin moved without cause");

	// buffer state follows the mode and action bits alone, so it never lags a select write
	a_out1_on: assert property (
		!st.sel1[3] && st.sel1[1:0] != 2'b00 |-> !CH1_PIN_OE_N)
		else $error("channel 1 pin not driven in compare mode");
	a_out2_on: assert property (
		!st.sel2[3] && st.sel2[1:0] != 2'b00 |-> !CH2_PIN_OE_N)
		else $error("channel 2 pin not driven in compare mode");
	a_cap1_undriven: assert property (
		st.sel1[3] |-> CH1_PIN_OE_N)
		else $error("channel 1 pin driven in capture mode");
	a_cap2_undriven: assert property (
		st.sel2[3] |-> CH2_PIN_OE_N)
		else $error("channel 2 pin driven in capture mode");

	// compare mode never loads the general register from the counter
	a_no_cap1: assert property (
		!st.sel1[3] |-> !c1.capture)
		else $error("channel 1 captured in compare mode");
	a_no_cap2: assert property (
		!st.sel2[3] |-> !c2.capture)
		else $error("channel 2 captured in compare mode");

	// channel 1 pin captures only on the selected edge
	a_ch1_cap_rise: assert property (
		CE && c1.capture && st.sel1[3:0] == 4'b1000 |-> s_pin1_rise)
		else $error("channel 1 rise capture without rising edge");
	a_ch1_cap_fall: assert property (
		CE && c1.capture && st.sel1[3:0] == 4'b1001 |-> s_pin1_fall)
		else $error("channel 1 fall capture without falling edge");
	a_ch1_cap_both: assert property (
		CE && c1.capture && (st.sel1[3:0] ==? 4'b101?) |-> s_pin1_edge)
		else $error("channel 1 both-edge capture without edge");

	// and no selected edge goes by without a capture
	a_ch1_fall_seen: assert property (
		(CE && st.sel1[3:0] == 4'b1001) and s_pin1_fall |-> c1.capture)
		else $error("channel 1 pin fall missed");
	a_ch1_both_seen: assert property (
		(CE && (st.sel1[3:0] ==? 4'b101?)) and s_pin1_edge |-> c1.capture)
		else $error("channel 1 pin edge missed");
	a_ch2_rise_seen: assert property (
		(CE && (st.sel2[3:0] ==? 4'b1?00)) and s_pin2_rise |-> c2.capture)
		else $error("channel 2 pin rise missed");
	a_ch2_fall_seen: assert property (
		(CE && (st.sel2[3:0] ==? 4'b1?01)) and s_pin2_fall |-> c2.capture)
		else $error("channel 2 pin fall missed");
	a_ch2_both_seen: assert property (
		(CE && (st.sel2[3:0] ==? 4'b1?1?)) and s_pin2_edge |-> c2.capture)
		else $error("channel 2 pin edge missed");
endmodule
`default_nettype wire

// File: verification/tios_far_model.sv
`timescale 1ns/1ps
`default_nettype none
// far side of both channels: counter values, pin levels and the channel 0 event
module tios_far_model (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [15:0] cnt_cmd,
	input  wire logic        pin_cmd,
	input  wire logic        ev_cmd,
	output logic      [15:0] cnt1,
	output logic      [15:0] cnt2,
	output logic             pin1,
	output logic             pin2,
	output logic             ev
);
	// launched from the clock so the block sees synchronous inputs;
	// channel 2 count is offset so a capture from the wrong counter shows
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt1 <= 16'h0000;
			cnt2 <= 16'h0f0f;
			pin1 <= 1'b0;
			pin2 <= 1'b0;
			ev <= 1'b0;
		end else begin
			cnt1 <= cnt_cmd;
			cnt2 <= cnt_cmd ^ 16'h0f0f;
			pin1 <= pin_cmd;
			pin2 <= pin_cmd;
			ev <= ev_cmd & ~ev; // one pulse per request cycle; a lingering request pulses every other cycle
		end
	end
endmodule
`default_nettype wire

// File: verification/timer_reg_a_io_select_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module timer_reg_a_io_select_tb_top;
	typedef struct packed {logic [3:0] code; logic oen; logic ini; logic aft;} tios_orow_t;
	typedef struct packed {logic [1:0] ch; logic [3:0] code; logic r; logic f; logic e;} tios_crow_t;
	logic        clk = 0, rst = 1, ce = 1, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0, sa, ga;
	logic [31:0] pwdata = 0, prdata, q;
	logic [3:0]  strb = 4'hf;
	logic [15:0] cnt_cmd = 0, cnt1, cnt2, x, g;
	logic        pready, pslverr, pc = 0, evc = 0, ev, p1, p2, po1, poe1, po2, poe2, er;
	int          fails = 0, comparisons = 0, cyc = 0;
	tios_orow_t  orow [8] = '{'{4'h0,1,0,0}, '{4'h1,0,0,0}, '{4'h2,0,0,1}, '{4'h3,0,0,1},
		'{4'h4,1,1,1}, '{4'h5,0,1,0}, '{4'h6,0,1,1}, '{4'h7,0,1,0}};
	tios_crow_t  crow [9] = '{'{2'd1,4'h8,1,0,0}, '{2'd1,4'h9,0,1,0}, '{2'd1,4'ha,1,1,0},
		'{2'd1,4'hb,1,1,0}, '{2'd1,4'hc,0,0,1}, '{2'd2,4'h8,1,0,0}, '{2'd2,4'hd,0,1,0},
		'{2'd2,4'he,1,1,0}, '{2'd2,4'hc,1,0,0}};
	tios_top dut (.CLK(clk), .RST(rst), .CE(ce), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PSTRB(strb), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .CNT1(cnt1), .CNT2(cnt2), .CH0_EVENT(ev), .CH1_PIN_I(p1),
		.CH1_PIN_O(po1), .CH1_PIN_OE_N(poe1), .CH2_PIN_I(p2), .CH2_PIN_O(po2), .CH2_PIN_OE_N(poe2));
	tios_far_model far (.clk(clk), .rst(rst), .cnt_cmd(cnt_cmd), .pin_cmd(pc), .ev_cmd(evc),
		.cnt1(cnt1), .cnt2(cnt2), .pin1(p1), .pin2(p2), .ev(ev));
	// 200 MHz
	always #2.5 clk = ~clk;
	// cut a hang short
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			end_sim();
		end
	end
	task tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		comparisons++;
		if (s !== e) begin
			fails++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask
	// one apb transfer; waits as long as the slave holds pready low
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1, a, d, q, er);
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e, input string nm);
		apb(0, a, 0, q, er);
		chk(nm, e, q);
	endtask
	task end_sim;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// main sequence: reset, output rows, capture rows, then the awkward cases
	initial begin
		tick(3);
		rst <= 0;
		rd(12'h000, 0, "sel1 reset");
		rd(12'h00c, 32'h0000_ffff, "gra2 reset");
		rd(12'h010, 0, "status reset");
		chk("oe_n reset", 1, 32'({poe1, poe2} == 2'b11));
		for (int c = 1; c <= 2; c++) begin
			sa = (c == 1) ? 12'h000 : 12'h004;
			// channel 2 sees the offset counter, so its match value is offset the same way
			wr(sa + 12'h008, (c == 1) ? 32'h0000_0123 : 32'h0000_0e2c);
			foreach (orow[i]) begin
				wr(sa, 32'(orow[i].code));
				tick(3);
				chk("oe_n", 32'(orow[i].oen), 32'(c == 1 ? poe1 : poe2));
				if (!orow[i].oen) chk("pin init", 32'(orow[i].ini), 32'(c == 1 ? po1 : po2));
				cnt_cmd <= 16'h0123;
				tick(4);
				if (!orow[i].oen) chk("pin match", 32'(orow[i].aft), 32'(c == 1 ? po1 : po2));
				cnt_cmd <= 16'h0000;
			end
		end
		foreach (crow[i]) begin
			sa = (crow[i].ch == 1) ? 12'h000 : 12'h004;
			ga = sa + 12'h008;
			x = (crow[i].ch == 1) ? 16'h0000 : 16'h0f0f;
			g = 0;
			wr(ga, 0);
			wr(sa, 32'(crow[i].code));
			tick(3);
			pc <= 1;
			cnt_cmd <= 16'h1100;
			tick(4);
			if (crow[i].r) g = 16'h1100 ^ x;
			rd(ga, 32'(g), "gra rise");
			pc <= 0;
			cnt_cmd <= 16'h2200;
			tick(4);
			if (crow[i].f) g = 16'h2200 ^ x;
			rd(ga, 32'(g), "gra fall");
			evc <= 1;
			cnt_cmd <= 16'h3300;
			tick(1);
			evc <= 0;
			tick(4);
			if (crow[i].e) g = 16'h3300 ^ x;
			rd(ga, 32'(g), "gra event");
		end
		apb(0, 12'h020, 0, q, er);
		chk("slverr", 1, 32'(er));
		chk("bad rdata", 0, q);
		apb(1, 12'h010, 32'h0000_000f, q, er);
		chk("status err", 0, 32'(er));
		wr(12'h008, 0);
		strb <= 4'h2;
		wr(12'h008, 32'h0000_55aa);
		strb <= 4'hf;
		rd(12'h008, 32'h0000_5500, "lane");
		ce <= 0;
		tick(1);
		chk("pready", 0, 32'(pready));
		ce <= 1;
		wr(12'h000, 32'h0000_0006);
		rst <= 1;
		tick(2);
		rst <= 0;
		rd(12'h000, 0, "sel1 rerst");
		chk("oe_n rerst", 1, 32'(poe1));
		end_sim();
	end
endmodule
`default_nettype wire
